// ==== dv/bst_tap_port_bench.sv ====
// Self-checking bench for the boundary-scan test port.
// Assumes the tester model drives the test clock domain.
`timescale 1ns/1ps
module bst_tap_port_bench;
   localparam logic [31:0] ID = 32'h2c4e_6a9b;  // Arbitrary identity, bit 0 set
   logic       clk_sys = 1'b0;
   logic       rst     = 1'b1;
   logic       tck, tms, tdi, tdo, tdo_oe;
   logic [7:0] core_out = 8'ha5;
   logic [7:0] core_oe  = 8'h3c;
   logic [7:0] pad      = 8'h5a;
   logic [7:0] pin_out, pin_oe;
   logic [3:0] instr;
   logic [2:0] gp_in;
   logic       gp_out = 1'b0;
   logic       gp_oe  = 1'b0;
   int         failures = 0;
   int         compares = 0;

   always #10 clk_sys = ~clk_sys;

   bst_tap_port #(.ID_VALUE(ID)) uut (
      .clk_sys_in(clk_sys), .rst_in(rst), .tck_in(tck), .tms_in(tms),
      .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .core_out_in(core_out),
      .core_oe_in(core_oe), .pad_in(pad), .pin_out_out(pin_out),
      .pin_oe_out(pin_oe), .gp_in_out(gp_in), .gp_out_in(gp_out), .gp_oe_in(gp_oe),
      .instr_out(instr));

   bst_tester tst (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo),
                   .tdo_oe_in(tdo_oe));

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      compares++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk

   task automatic wclk(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wclk

   task automatic ir(input logic [3:0] code);
      logic [31:0] d;
      tst.scan(1'b1, 4, {28'h0, code}, d);
      chk(d[3:0], 4'h1, "ir capture");
      chk(instr, code, "instruction");
   endtask : ir

   // Cell k*3+sel of a 24-cell image, per pin
   function automatic logic [7:0] cells(input logic [23:0] p, input int sel);
      for (int i = 0; i < 8; i++) cells[i] = p[3 * i + sel];
   endfunction : cells

   task automatic t_reset;
      tst.ones(6, 1'b0);
      @(posedge clk_sys) rst <= 1'b0;
      tst.ones(6, 1'b1);
      wclk(2);
      chk(gp_in, 3'h0, "general inputs idle");
      chk(instr, 4'h1, "reset instruction");
      chk(tdo_oe, 1'b0, "tdo idle drive");
      chk({pin_oe, pin_out}, {core_oe, core_out}, "pins follow core");
   endtask : t_reset

   task automatic t_idcode;
      logic [31:0] d;
      ir(4'h1);
      tst.scan(1'b0, 32, 32'h0, d);
      chk(d, ID, "identity");
      chk(tst.oe_miss, 0, "tdo drive in shift");
      chk(tdo_oe, 1'b0, "tdo drive after shift");
   endtask : t_idcode

   // Bypass, all-outputs-float and unassigned codes share the one-bit path
   task automatic t_bypass;
      logic [3:0]  codes [5] = '{4'hf, 4'h5, 4'h9, 4'hc, 4'h3};
      logic [31:0] d;
      foreach (codes[i]) begin
         ir(codes[i]);
         tst.scan(1'b0, 8, 32'hb4, d);
         chk(d[7:1], 7'h34, "bypass path");
         wclk(8);
         chk(pin_oe, codes[i] == 4'h5 ? 8'h00 : core_oe, "output float");
      end
   endtask : t_bypass

   task automatic t_boundary;
      logic [23:0] p = 24'h6d2b97;
      logic [31:0] d;
      ir(4'h2);
      tst.scan(1'b0, 24, {8'h0, p}, d);
      chk(d[23:0], snap(), "snapshot");
      wclk(8);
      chk(pin_out, core_out, "pins in sample");
      ir(4'h0);
      wclk(8);
      chk(pin_out, cells(p, 0), "extest data");
      chk(pin_oe, cells(p, 1), "extest enable");
      chk(tst.oe_miss, 0, "tdo drive in every shift");
   endtask : t_boundary

   function automatic logic [23:0] snap();
      for (int i = 0; i < 8; i++) snap[3 * i +: 3] = {pad[i], core_oe[i], core_out[i]};
   endfunction : snap

   task automatic end_of_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   initial begin
      t_reset;
      t_idcode;
      t_bypass;
      t_boundary;
      end_of_test;
   end

   // Whole run is near 12 us; this is a wide margin
   initial begin
      #200000;
      failures++;
      end_of_test;
   end
endmodule : bst_tap_port_bench

// ==== dv/bst_tester.sv ====
// Tester model for the four-wire test port.
// Assumes the port samples on rising and updates its output on falling test clock edges.
`timescale 1ns/1ps
module bst_tester (
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out,
   input  wire logic tdo_in,
   input  wire logic tdo_oe_in
);
   int oe_miss = 0;

   initial begin
      tck_out = 1'b0;  // Clock stands still between frames
      tms_out = 1'b1;
      tdi_out = 1'b1;  // Pulled-up line while released
   end

   // Sets tms/tdi mid-low phase, returns tdo as seen before the rising edge
   task automatic tick(input logic m, input logic d, output logic o);
      o = (tdo_oe_in === 1'b1) ? tdo_in : 1'b1;  // Pulled-up line while released
      tms_out = m;
      tdi_out = d;
      #12 tck_out = 1'b1;
      #24 tck_out = 1'b0;
      #12;
   endtask : tick

   task automatic ones(input int n, input bit to_idle);
      logic o;
      repeat (n) tick(1'b1, 1'b1, o);
      if (to_idle) tick(1'b0, 1'b1, o);
      tms_out = 1'b1;
   endtask : ones

   // From idle: instruction or data scan of n bits, LSB first, back to idle
   task automatic scan(input bit ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic o;
      dout = '0;
      tick(1'b1, 1'b1, o);
      if (ir) tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
      tick(1'b0, 1'b1, o);
      for (int k = 0; k < n; k++) begin
         if (tdo_oe_in !== 1'b1) oe_miss++;
         tick(k == n - 1, din[k], o);
         dout[k] = o;
      end
      tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
      tms_out = 1'b1;
      tdi_out = 1'b1;
   endtask : scan
endmodule : bst_tester

// ==== rtl/bst_bsr.sv ====
// Boundary-scan register: capture/shift stage plus latched update stage.
// Assumes controls come from the test access controller on the same clock.
`timescale 1ns/1ps
`include "bst_defs.svh"
module bst_bsr #(
   parameter int W = `BST_CELLS
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         capture_in,
   input  wire logic         shift_in,
   input  wire logic         update_in,
   input  wire logic [W-1:0] par_in,
   input  wire logic         si_in,
   output logic              so_out,
   output logic      [W-1:0] upd_out
);

   logic [W-1:0] shift_reg;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         shift_reg <= '0;
      end else if (capture_in) begin
         shift_reg <= par_in;
      end else if (shift_in) begin
         shift_reg <= {si_in, shift_reg[W-1:1]};
      end
   end

   // Latched outputs only move on update, so preloads hold across later scans
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         upd_out <= '0;
      end else if (update_in) begin
         upd_out <= shift_reg;
      end
   end

   assign so_out = shift_reg[0];

   AST_BSR_CAPTURE: assert property (@(posedge clk_in) disable iff (rst_in)
      capture_in |=> shift_reg == $past(par_in))
      else $error("boundary register missed its capture");

   AST_BSR_PRELOAD: assert property (@(posedge clk_in) disable iff (rst_in)
      update_in ##1 !update_in [*3] |-> upd_out == $past(shift_reg, 3))
      else $error("boundary preload not held");

endmodule : bst_bsr

// ==== rtl/bst_defs.svh ====
// Constants of the boundary-scan test access port.
// Assumes inclusion by bare name from rtl/ files only.
//
// Summary of operation
// - Four-wire test port: clock, mode select, data in, data out; no test reset pin.
// - Power-up reset resets the test access controller instead of a reset pin.
// - Test clock advances the controller and clocks all serial shifting.
// - Serial data input is sampled on the rising test clock edge.
// - Serial data output changes on the falling test clock edge while shifting.
// - Serial data output floats whenever no shift is in progress.
// - Build option chooses test port or general I/O; buried logic stays usable.
// - Code 0010 samples pins into boundary register and preloads its latched outputs.
// - Code 0000 drives pins from latched boundary outputs for interconnect tests.
// - Code 1111 puts a one-bit bypass stage between data in and out.
// - Holding data in high through an instruction scan loads bypass.
// - Code 0001 shifts the identification register out serially.
// - Code 0101 floats every system logic output.
// - During the output-float instruction the bypass stage sits in the scan path.
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

`define BST_IR_W        4
`define BST_IR_EXTEST   4'h0
`define BST_IR_IDCODE   4'h1
`define BST_IR_SAMPLE   4'h2
`define BST_IR_ALL_OUTPUTS_FLOAT_INSTRUCTION    4'h5
`define BST_IR_BYPASS   4'hf
`define BST_IR_CAPTURE  4'h1
`define BST_ID_W        32
`define BST_PINS        8
`define BST_CELLS       24
`define BST_CELL_OUT    0
`define BST_CELL_OE     1
`define BST_CELL_IN     2
`define BST_CELL_STRIDE 3
`define BST_GP_W        3

`endif

// ==== rtl/bst_pkg.sv ====
// Types of the boundary-scan test access port.
// Assumes nothing beyond a SystemVerilog compiler.
package bst_pkg;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE,
      TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
      TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } bst_tap_state_t;

endpackage : bst_pkg

// ==== rtl/bst_sync2.sv ====
// Two-flop level synchroniser, one stage pair per bit.
// Assumes d_in is stable for at least two destination clock edges.
`timescale 1ns/1ps
module bst_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_reg <= '0;
         q_out    <= '0;
      end else begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end

endmodule : bst_sync2

// ==== rtl/bst_tap_port.sv ====
// Boundary-scan test access port: controller, instruction, bypass, identity, boundary.
// Assumes tck_in is the tester clock, unrelated to clk_sys_in, and running while
// rst_in is asserted so the power-up reset reaches the controller.
`timescale 1ns/1ps
`include "bst_defs.svh"
module bst_tap_port #(
   parameter bit                    TEST_PORT_EN = 1'b1,
   parameter logic [`BST_ID_W-1:0] ID_VALUE     = 32'h0000_0001  // Arbitrary identity
) (
   input  wire logic                 clk_sys_in,
   input  wire logic                 rst_in,
   input  wire logic                 tck_in,
   input  wire logic                 tms_in,
   input  wire logic                 tdi_in,
   output logic                      tdo_out,
   output logic                      tdo_oe_out,
   input  wire logic [`BST_PINS-1:0] core_out_in,
   input  wire logic [`BST_PINS-1:0] core_oe_in,
   input  wire logic [`BST_PINS-1:0] pad_in,
   output logic      [`BST_PINS-1:0] pin_out_out,
   output logic      [`BST_PINS-1:0] pin_oe_out,
   output logic      [`BST_GP_W-1:0] gp_in_out,
   input  wire logic                 gp_out_in,
   input  wire logic                 gp_oe_in,
   output logic      [`BST_IR_W-1:0] instr_out
);

   // ------------------------------------------------------------
   // Reset into the test clock domain
   // ------------------------------------------------------------
   logic rst_tck;

   bst_sync2 #(.W(1)) u_rst_sync (
      .clk_in (tck_in),
      .rst_in (1'b0),
      .d_in   (rst_in),
      .q_out  (rst_tck)
   );

   // ------------------------------------------------------------
   // Controller state machine
   // ------------------------------------------------------------
   bst_pkg::bst_tap_state_t state_reg;
   bst_pkg::bst_tap_state_t state_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         bst_pkg::TAP_RESET:    state_next = tms_in ? bst_pkg::TAP_RESET    : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_IDLE:     state_next = tms_in ? bst_pkg::TAP_SEL_DR   : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_SEL_DR:   state_next = tms_in ? bst_pkg::TAP_SEL_IR   : bst_pkg::TAP_CAP_DR;
         bst_pkg::TAP_CAP_DR:   state_next = tms_in ? bst_pkg::TAP_EXIT1_DR : bst_pkg::TAP_SHIFT_DR;
         bst_pkg::TAP_SHIFT_DR: state_next = tms_in ? bst_pkg::TAP_EXIT1_DR : bst_pkg::TAP_SHIFT_DR;
         bst_pkg::TAP_EXIT1_DR: state_next = tms_in ? bst_pkg::TAP_UPD_DR   : bst_pkg::TAP_PAUSE_DR;
         bst_pkg::TAP_PAUSE_DR: state_next = tms_in ? bst_pkg::TAP_EXIT2_DR : bst_pkg::TAP_PAUSE_DR;
         bst_pkg::TAP_EXIT2_DR: state_next = tms_in ? bst_pkg::TAP_UPD_DR   : bst_pkg::TAP_SHIFT_DR;
         bst_pkg::TAP_UPD_DR:   state_next = tms_in ? bst_pkg::TAP_SEL_DR   : bst_pkg::TAP_IDLE;
         bst_pkg::TAP_SEL_IR:   state_next = tms_in ? bst_pkg::TAP_RESET    : bst_pkg::TAP_CAP_IR;
         bst_pkg::TAP_CAP_IR:   state_next = tms_in ? bst_pkg::TAP_EXIT1_IR : bst_pkg::TAP_SHIFT_IR;
         bst_pkg::TAP_SHIFT_IR: state_next = tms_in ? bst_pkg::TAP_EXIT1_IR : bst_pkg::TAP_SHIFT_IR;
         bst_pkg::TAP_EXIT1_IR: state_next = tms_in ? bst_pkg::TAP_UPD_IR   : bst_pkg::TAP_PAUSE_IR;
         bst_pkg::TAP_PAUSE_IR: state_next = tms_in ? bst_pkg::TAP_EXIT2_IR : bst_pkg::TAP_PAUSE_IR;
         bst_pkg::TAP_EXIT2_IR: state_next = tms_in ? bst_pkg::TAP_UPD_IR   : bst_pkg::TAP_SHIFT_IR;
         bst_pkg::TAP_UPD_IR:   state_next = tms_in ? bst_pkg::TAP_SEL_DR   : bst_pkg::TAP_IDLE;
         default:               state_next = bst_pkg::TAP_RESET;
      endcase
   end

   // Controller parked in reset when the pins serve as general I/O
   always_ff @(posedge tck_in) begin
      if (rst_tck || !TEST_PORT_EN) begin
         state_reg <= bst_pkg::TAP_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   logic shift_ir;
   logic shift_dr;
   assign shift_ir = (state_reg == bst_pkg::TAP_SHIFT_IR);
   assign shift_dr = (state_reg == bst_pkg::TAP_SHIFT_DR);

   // ------------------------------------------------------------
   // Instruction register
   // ------------------------------------------------------------
   logic [`BST_IR_W-1:0] ir_shift_reg;
   logic [`BST_IR_W-1:0] ir_reg;

   always_ff @(posedge tck_in) begin
      if (rst_tck) begin
         ir_shift_reg <= `BST_IR_CAPTURE;
      end else if (state_reg == bst_pkg::TAP_CAP_IR) begin
         ir_shift_reg <= `BST_IR_CAPTURE;
      end else if (shift_ir) begin
         ir_shift_reg <= {tdi_in, ir_shift_reg[`BST_IR_W-1:1]};
      end
   end

   always_ff @(posedge tck_in) begin
      if (rst_tck || state_reg == bst_pkg::TAP_RESET) begin
         ir_reg <= `BST_IR_IDCODE;
      end else if (state_reg == bst_pkg::TAP_UPD_IR) begin
         ir_reg <= ir_shift_reg;
      end
   end

   assign instr_out = ir_reg;

   // ------------------------------------------------------------
   // Instruction decode
   // ------------------------------------------------------------
   logic sel_bsr;
   logic sel_id;
   logic sel_byp;
   logic ir_extest;
   logic ir_all_outputs_float_instruction;

   assign ir_extest = (ir_reg == `BST_IR_EXTEST);
   assign ir_all_outputs_float_instruction  = (ir_reg == `BST_IR_ALL_OUTPUTS_FLOAT_INSTRUCTION);
   assign sel_bsr   = ir_extest || (ir_reg == `BST_IR_SAMPLE);
   assign sel_id    = (ir_reg == `BST_IR_IDCODE);
   // Float, bypass and every other code (programming codes too) use bypass
   assign sel_byp   = !sel_bsr && !sel_id;

   // ------------------------------------------------------------
   // Bypass and identification paths
   // ------------------------------------------------------------
   logic                 bypass_reg;
   logic [`BST_ID_W-1:0] id_shift_reg;

   always_ff @(posedge tck_in) begin
      if (rst_tck || state_reg == bst_pkg::TAP_CAP_DR) begin
         bypass_reg <= 1'b0;
      end else if (shift_dr && sel_byp) begin
         bypass_reg <= tdi_in;
      end
   end

   always_ff @(posedge tck_in) begin
      if (rst_tck) begin
         id_shift_reg <= ID_VALUE;
      end else if (state_reg == bst_pkg::TAP_CAP_DR && sel_id) begin
         id_shift_reg <= ID_VALUE;
      end else if (shift_dr && sel_id) begin
         id_shift_reg <= {tdi_in, id_shift_reg[`BST_ID_W-1:1]};
      end
   end

   // ------------------------------------------------------------
   // Boundary-scan register
   // ------------------------------------------------------------
   logic [`BST_PINS-1:0]  core_out_tck;
   logic [`BST_PINS-1:0]  core_oe_tck;
   logic [`BST_PINS-1:0]  pad_tck;
   logic [`BST_CELLS-1:0] cap_vec;
   logic [`BST_CELLS-1:0] upd_vec;
   logic                  bsr_so;

   // Pads and core signals are foreign to the test clock
   bst_sync2 #(.W(`BST_CELLS)) u_cap_sync (
      .clk_in (tck_in),
      .rst_in (rst_tck),
      .d_in   ({pad_in, core_oe_in, core_out_in}),
      .q_out  ({pad_tck, core_oe_tck, core_out_tck})
   );

   for (genvar i = 0; i < `BST_PINS; i++) begin : g_cells
      assign cap_vec[`BST_CELL_STRIDE*i + `BST_CELL_OUT] = core_out_tck[i];
      assign cap_vec[`BST_CELL_STRIDE*i + `BST_CELL_OE]  = core_oe_tck[i];
      assign cap_vec[`BST_CELL_STRIDE*i + `BST_CELL_IN]  = pad_tck[i];
   end

   bst_bsr #(.W(`BST_CELLS)) u_bsr (
      .clk_in     (tck_in),
      .rst_in     (rst_tck),
      .capture_in (state_reg == bst_pkg::TAP_CAP_DR && sel_bsr),
      .shift_in   (shift_dr && sel_bsr),
      .update_in  (state_reg == bst_pkg::TAP_UPD_DR && sel_bsr),
      .par_in     (cap_vec),
      .si_in      (tdi_in),
      .so_out     (bsr_so),
      .upd_out    (upd_vec)
   );

   // ------------------------------------------------------------
   // Serial output on the falling edge
   // ------------------------------------------------------------
   logic tdo_reg;
   logic tdo_en_reg;
   logic dr_so;

   assign dr_so = sel_bsr ? bsr_so : (sel_id ? id_shift_reg[0] : bypass_reg);

   always_ff @(negedge tck_in) begin
      if (rst_tck) begin
         tdo_reg    <= 1'b0;
         tdo_en_reg <= 1'b0;
      end else begin
         if (shift_ir) begin
            tdo_reg <= ir_shift_reg[0];
         end else if (shift_dr) begin
            tdo_reg <= dr_so;
         end
         tdo_en_reg <= shift_ir || shift_dr;
      end
   end

   // ------------------------------------------------------------
   // Mode and preload crossing into the system clock domain
   // ------------------------------------------------------------
   logic upd_tgl_reg;
   logic ext_mode_reg;
   logic hz_mode_reg;

   always_ff @(posedge tck_in) begin
      if (rst_tck) begin
         upd_tgl_reg  <= 1'b0;
         ext_mode_reg <= 1'b0;
         hz_mode_reg  <= 1'b0;
      end else begin
         if (state_reg == bst_pkg::TAP_UPD_DR && sel_bsr) begin
            upd_tgl_reg <= !upd_tgl_reg;
         end
         // Mode follows the new code at once: the tester may stop the clock in idle
         if (state_reg == bst_pkg::TAP_RESET) begin
            ext_mode_reg <= 1'b0;
            hz_mode_reg  <= 1'b0;
         end else if (state_reg == bst_pkg::TAP_UPD_IR) begin
            ext_mode_reg <= (ir_shift_reg == `BST_IR_EXTEST);
            hz_mode_reg  <= (ir_shift_reg == `BST_IR_ALL_OUTPUTS_FLOAT_INSTRUCTION);
         end
      end
   end

   logic upd_tgl_sys;
   logic ext_sys;
   logic hz_sys;
   logic upd_tgl_seen_reg;

   bst_sync2 #(.W(3)) u_mode_sync (
      .clk_in (clk_sys_in),
      .rst_in (rst_in),
      .d_in   ({upd_tgl_reg, ext_mode_reg, hz_mode_reg}),
      .q_out  ({upd_tgl_sys, ext_sys, hz_sys})
   );

   // Safe to copy: upd_vec holds still for many test clocks after its toggle
   logic [`BST_PINS-1:0] upd_data_sys_reg;
   logic [`BST_PINS-1:0] upd_oe_sys_reg;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         upd_tgl_seen_reg <= 1'b0;
         upd_data_sys_reg <= '0;
         upd_oe_sys_reg   <= '0;
      end else begin
         upd_tgl_seen_reg <= upd_tgl_sys;
         if (upd_tgl_sys != upd_tgl_seen_reg) begin
            for (int i = 0; i < `BST_PINS; i++) begin
               upd_data_sys_reg[i] <= upd_vec[`BST_CELL_STRIDE*i + `BST_CELL_OUT];
               upd_oe_sys_reg[i]   <= upd_vec[`BST_CELL_STRIDE*i + `BST_CELL_OE];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // System pin drivers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pin_out_out <= '0;
         pin_oe_out  <= '0;
      end else if (hz_sys) begin
         pin_out_out <= core_out_in;
         pin_oe_out  <= '0;
      end else if (ext_sys) begin
         pin_out_out <= upd_data_sys_reg;
         pin_oe_out  <= upd_oe_sys_reg;
      end else begin
         pin_out_out <= core_out_in;
         pin_oe_out  <= core_oe_in;
      end
   end

   // ------------------------------------------------------------
   // Test pins as general I/O when the port is not built in
   // ------------------------------------------------------------
   logic [`BST_GP_W-1:0] gp_raw_sys;
   logic                 gp_out_reg;
   logic                 gp_oe_reg;

   bst_sync2 #(.W(`BST_GP_W)) u_gp_sync (
      .clk_in (clk_sys_in),
      .rst_in (rst_in),
      .d_in   ({tck_in, tms_in, tdi_in}),
      .q_out  (gp_raw_sys)
   );

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         gp_out_reg <= 1'b0;
         gp_oe_reg  <= 1'b0;
      end else begin
         gp_out_reg <= gp_out_in;
         gp_oe_reg  <= gp_oe_in && !TEST_PORT_EN;
      end
   end

   assign gp_in_out  = TEST_PORT_EN ? '0 : gp_raw_sys;
   assign tdo_out    = TEST_PORT_EN ? tdo_reg : gp_out_reg;
   assign tdo_oe_out = TEST_PORT_EN ? tdo_en_reg : gp_oe_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_tms_held;
      tms_in [*5];
   endsequence

   sequence s_ir_all_ones;
      (shift_ir && tdi_in) [*4] ##1 (state_reg == bst_pkg::TAP_EXIT1_IR)
         ##1 (state_reg == bst_pkg::TAP_UPD_IR);
   endsequence

   AST_TMS_RESET: assert property (@(posedge tck_in) disable iff (rst_tck)
      s_tms_held |=> state_reg == bst_pkg::TAP_RESET)
      else $error("five high mode selects did not reset controller");

   AST_IR_CAPTURE: assert property (@(posedge tck_in) disable iff (rst_tck)
      state_reg == bst_pkg::TAP_CAP_IR |=> ir_shift_reg == `BST_IR_CAPTURE)
      else $error("instruction capture pattern wrong");

   AST_ONES_BYPASS: assert property (@(posedge tck_in) disable iff (rst_tck)
      s_ir_all_ones |=> ir_reg == `BST_IR_BYPASS && sel_byp)
      else $error("all-ones instruction scan did not load bypass");

   AST_TDO_FLOAT: assert property (@(posedge tck_in) disable iff (rst_tck)
      TEST_PORT_EN && !$past(shift_ir) && !$past(shift_dr) && !shift_ir && !shift_dr
         |-> !tdo_oe_out)
      else $error("serial output driven outside a shift");

   AST_TDO_IR_FALL: assert property (@(posedge tck_in) disable iff (rst_tck)
      TEST_PORT_EN && shift_ir |-> tdo_out == ir_shift_reg[0] && tdo_oe_out)
      else $error("serial output not updated on falling edge");

   AST_BYPASS_DELAY: assert property (@(posedge tck_in) disable iff (rst_tck)
      TEST_PORT_EN && sel_byp && shift_dr ##1 shift_dr |-> tdo_out == $past(tdi_in))
      else $error("bypass path not one stage");

   AST_ALL_OUTPUTS_FLOAT_INSTRUCTION_BYPASS: assert property (@(posedge tck_in) disable iff (rst_tck)
      ir_all_outputs_float_instruction && state_reg == bst_pkg::TAP_CAP_DR ##1 shift_dr |-> tdo_out == 1'b0)
      else $error("float instruction lacks bypass capture");

   AST_UNKNOWN_BYPASS: assert property (@(posedge tck_in) disable iff (rst_tck)
      state_reg == bst_pkg::TAP_UPD_IR && ir_shift_reg inside {4'h3, 4'h4, 4'h6, 4'h7}
         |=> sel_byp && !sel_bsr && !sel_id)
      else $error("unassigned code not treated as bypass");

   AST_ID_LOAD: assert property (@(posedge tck_in) disable iff (rst_tck)
      sel_id && state_reg == bst_pkg::TAP_CAP_DR |=> id_shift_reg == ID_VALUE)
      else $error("identity not captured");

   AST_ALL_OUTPUTS_FLOAT_INSTRUCTION_PINS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      hz_sys |=> pin_oe_out == '0)
      else $error("outputs not floated");

   AST_EXTEST_PINS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      ext_sys && !hz_sys |=> pin_out_out == $past(upd_data_sys_reg)
         && pin_oe_out == $past(upd_oe_sys_reg))
      else $error("pins not driven from latched boundary outputs");

endmodule : bst_tap_port
